// ### pkg/rx_latch_pkg.sv
// constants and types shared by the receiver latch bank
package rx_latch_pkg;

	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// ----------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------
	localparam logic [15:0] IDX_ATTEN = 16'h8000;
	localparam logic [15:0] IDX_PHASE = 16'h8001;
	localparam logic [15:0] IDX_GTRIM = 16'h8002;
	localparam logic [15:0] IDX_RF_STAGE = 16'h8006;
	localparam logic [15:0] IDX_IF_STAGE = 16'h8007;
	localparam logic [15:0] IDX_OFS_A = 16'h8010;
	localparam logic [15:0] IDX_OFS_B = 16'h8011;
	localparam logic [15:0] IDX_RX_GAIN = 16'h8012;
	localparam logic [15:0] IDX_CMD = 16'h8013;
	localparam logic [15:0] IDX_STATUS = 16'h8014;

	// ----------------------------------------
	// stage pattern fields
	// ----------------------------------------
	localparam int STAGE_W = 10;
	localparam int RF_LSB = 0;
	localparam int RF_W = 4;
	localparam int IF_LSB = 4;
	localparam int IF_W = 4;
	localparam int SECOND_LSB = 8;
	localparam int SECOND_W = 2;
	localparam int HI_W = IF_W + SECOND_W;

	// ----------------------------------------
	// receiver gain limits
	// ----------------------------------------
	localparam logic [15:0] RX_GAIN_MIN = 16'h0001;
	localparam logic [15:0] RX_GAIN_MAX = 16'hb505;

	// ----------------------------------------
	// status bits
	// ----------------------------------------
	localparam int ST_ERROR = 0;
	localparam int ST_BLANK = 1;
	localparam int ST_HOLD = 2;
	localparam int ST_RED = 3;
	localparam int ST_GREEN = 4;

	// ----------------------------------------
	// commands, written to the command register
	// ----------------------------------------
	typedef enum logic [3:0] {
		CMD_NONE = 4'h0,
		CMD_INC_GTRIM = 4'h1,
		CMD_DEC_GTRIM = 4'h2,
		CMD_INC_PHASE = 4'h3,
		CMD_DEC_PHASE = 4'h4,
		CMD_INC_OFS_A = 4'h5,
		CMD_DEC_OFS_A = 4'h6,
		CMD_INC_OFS_B = 4'h7,
		CMD_DEC_OFS_B = 4'h8,
		CMD_INIT = 4'h9,
		CMD_SAVE = 4'ha,
		CMD_CLR_ERR = 4'hb,
		CMD_QUAD_ENTER = 4'hc,
		CMD_QUAD_LEAVE = 4'hd
	} cmd_t;

	// ----------------------------------------
	// settings and their power-up defaults
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] atten;
		logic [7:0] phase;
		logic [7:0] gtrim;
		logic [STAGE_W-1:0] stage;
		logic [7:0] ofs_a;
		logic [7:0] ofs_b;
		logic [15:0] rx_gain;
	} settings_t;

	localparam settings_t SETTINGS_RST = '{
		atten: 8'h00,
		phase: 8'h80,
		gtrim: 8'h80,
		stage: 10'h000,
		ofs_a: 8'h80,
		ofs_b: 8'h80,
		rx_gain: 16'h0001
	};

endpackage

// ### rtl/rx_latch_bank.sv
// receiver gain, trim and offset latch bank with status indicators
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/1ps

// How it works
// - rf and if stages follow the pattern written to their stage latch
// - attenuator latch drives its converter continuously until rewritten
// - phase trim and gain trim latches each drive their own converter
// - with pulse reset disabled, red blinks and green stays lit
// - error lights red, darkens green, refuses operation until cleared
// - active acquisition pulse holds controller, suspends operation, both lit
// - channel a offset readable and writable, 0 to 255
// - channel b offset readable and writable, 0 to 255
// - increment raises gain, phase or offset by one step
// - decrement lowers gain, phase or offset by one step
// - quad entry inhibits pulse reset first; leaving re-enables it
// - initialize reloads every setting from stored defaults
// - save copies current settings into the defaults
// - receiver gain readable and writable from 1 to 46341
// - attenuator at 0x8000, phase at 0x8001, gain trim at 0x8002
// - rf stage latch at 0x8006, if and second stage at 0x8007
// - ten-bit stage pattern: rf 0-3, if 4-7, second stage 8-9
module rx_latch_bank #(
	parameter int BLINK_CYCLES = rx_latch_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [rx_latch_pkg::ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [rx_latch_pkg::DATA_W-1:0] writedata_i,
	input wire logic [rx_latch_pkg::BE_W-1:0] byteenable_i,
	input wire logic acquisition_pulse_n_i,
	input wire logic error_event_i,
	output logic [rx_latch_pkg::DATA_W-1:0] readdata_o,
	output logic waitrequest_o,
	output logic [7:0] fine_attenuator_value_o,
	output logic [7:0] quad_phase_trim_o,
	output logic [7:0] quad_gain_trim_o,
	output logic [rx_latch_pkg::RF_W+rx_latch_pkg::IF_W-1:0] switched_gain_stage_o,
	output logic [rx_latch_pkg::SECOND_W-1:0] second_stage_gain_o,
	output logic [7:0] chan_a_offset_o,
	output logic [7:0] chan_b_offset_o,
	output logic [15:0] rx_gain_o,
	output logic pulse_reset_inhibit_o,
	output logic controller_hold_o,
	output logic red_led_o,
	output logic green_led_o
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		rx_latch_pkg::settings_t cur;
		rx_latch_pkg::settings_t dflt;
		logic [rx_latch_pkg::DATA_W-1:0] rdata;
		logic wait_req;
		logic error;
		logic blank;
		logic hold;
		logic red;
		logic green;
		logic [31:0] blink_cnt;
		logic blink_ph;
	} state_t;

	localparam state_t STATE_RST = '{
		cur: rx_latch_pkg::SETTINGS_RST,
		dflt: rx_latch_pkg::SETTINGS_RST,
		rdata: 32'h0000_0000,
		wait_req: 1'b1,
		error: 1'b0,
		blank: 1'b0,
		hold: 1'b0,
		red: 1'b0,
		green: 1'b1,
		blink_cnt: 32'h0000_0000,
		blink_ph: 1'b0
	};

	state_t st_reg;
	state_t st_next;

	// saturating one-step move; wrapping would jump the converter end to end
	function automatic logic [7:0] step(input logic [7:0] v, input logic up);
		logic [7:0] r;
		r = v;
		if (up && v != 8'hff) begin
			r = v + 8'h01;
		end else if (!up && v != 8'h00) begin
			r = v - 8'h01;
		end
		return r;
	endfunction

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [15:0] idx;
	logic accept;
	logic wr_go;
	logic pulse_hold;
	logic cmd_seen;
	logic [15:0] gain_wr;
	rx_latch_pkg::cmd_t cmd;

	assign idx = address_i[rx_latch_pkg::ADDR_W-1:2];
	assign accept = (read_i || write_i) && !st_reg.wait_req;
	assign pulse_hold = !acquisition_pulse_n_i && !st_reg.blank;
	// while held, writes are dropped; in error, all but the clear-error command are; all are still answered
	assign wr_go = accept && write_i && byteenable_i[0] && !pulse_hold;
	assign cmd = rx_latch_pkg::cmd_t'(writedata_i[3:0]);
	assign cmd_seen = write_i && st_reg.wait_req && idx == rx_latch_pkg::IDX_CMD;
	assign gain_wr = {byteenable_i[1] ? writedata_i[15:8] : st_reg.cur.rx_gain[15:8], writedata_i[7:0]};

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.wait_req = !((read_i || write_i) && st_reg.wait_req);
		st_next.hold = pulse_hold;

		if ((read_i || write_i) && st_reg.wait_req) begin
			st_next.rdata = 32'h0000_0000;
			if (read_i) begin
				unique case (idx)
					rx_latch_pkg::IDX_ATTEN: st_next.rdata[7:0] = st_reg.cur.atten;
					rx_latch_pkg::IDX_PHASE: st_next.rdata[7:0] = st_reg.cur.phase;
					rx_latch_pkg::IDX_GTRIM: st_next.rdata[7:0] = st_reg.cur.gtrim;
					rx_latch_pkg::IDX_RF_STAGE: begin
						st_next.rdata[rx_latch_pkg::RF_W-1:0] = st_reg.cur.stage[rx_latch_pkg::RF_LSB +: rx_latch_pkg::RF_W];
					end
					rx_latch_pkg::IDX_IF_STAGE: begin
						st_next.rdata[rx_latch_pkg::HI_W-1:0] = st_reg.cur.stage[rx_latch_pkg::IF_LSB +: rx_latch_pkg::HI_W];
					end
					rx_latch_pkg::IDX_OFS_A: st_next.rdata[7:0] = st_reg.cur.ofs_a;
					rx_latch_pkg::IDX_OFS_B: st_next.rdata[7:0] = st_reg.cur.ofs_b;
					rx_latch_pkg::IDX_RX_GAIN: st_next.rdata[15:0] = st_reg.cur.rx_gain;
					rx_latch_pkg::IDX_STATUS: begin
						st_next.rdata[rx_latch_pkg::ST_ERROR] = st_reg.error;
						st_next.rdata[rx_latch_pkg::ST_BLANK] = st_reg.blank;
						st_next.rdata[rx_latch_pkg::ST_HOLD] = st_reg.hold;
						st_next.rdata[rx_latch_pkg::ST_RED] = st_reg.red;
						st_next.rdata[rx_latch_pkg::ST_GREEN] = st_reg.green;
					end
					default: st_next.rdata = 32'h0000_0000;
				endcase
			end
		end

		if (wr_go && !st_reg.error) begin
			unique case (idx)
				rx_latch_pkg::IDX_ATTEN: st_next.cur.atten = writedata_i[7:0];
				rx_latch_pkg::IDX_PHASE: st_next.cur.phase = writedata_i[7:0];
				rx_latch_pkg::IDX_GTRIM: st_next.cur.gtrim = writedata_i[7:0];
				rx_latch_pkg::IDX_RF_STAGE: begin
					st_next.cur.stage[rx_latch_pkg::RF_LSB +: rx_latch_pkg::RF_W] = writedata_i[rx_latch_pkg::RF_W-1:0];
				end
				rx_latch_pkg::IDX_IF_STAGE: begin
					st_next.cur.stage[rx_latch_pkg::IF_LSB +: rx_latch_pkg::HI_W] = writedata_i[rx_latch_pkg::HI_W-1:0];
				end
				rx_latch_pkg::IDX_OFS_A: st_next.cur.ofs_a = writedata_i[7:0];
				rx_latch_pkg::IDX_OFS_B: st_next.cur.ofs_b = writedata_i[7:0];
				rx_latch_pkg::IDX_RX_GAIN: begin
					// out-of-range gain is clamped, not refused
					if (gain_wr < rx_latch_pkg::RX_GAIN_MIN) begin
						st_next.cur.rx_gain = rx_latch_pkg::RX_GAIN_MIN;
					end else if (gain_wr > rx_latch_pkg::RX_GAIN_MAX) begin
						st_next.cur.rx_gain = rx_latch_pkg::RX_GAIN_MAX;
					end else begin
						st_next.cur.rx_gain = gain_wr;
					end
				end
				rx_latch_pkg::IDX_CMD: begin
					unique case (cmd)
						rx_latch_pkg::CMD_INC_GTRIM: st_next.cur.gtrim = step(st_reg.cur.gtrim, 1'b1);
						rx_latch_pkg::CMD_DEC_GTRIM: st_next.cur.gtrim = step(st_reg.cur.gtrim, 1'b0);
						rx_latch_pkg::CMD_INC_PHASE: st_next.cur.phase = step(st_reg.cur.phase, 1'b1);
						rx_latch_pkg::CMD_DEC_PHASE: st_next.cur.phase = step(st_reg.cur.phase, 1'b0);
						rx_latch_pkg::CMD_INC_OFS_A: st_next.cur.ofs_a = step(st_reg.cur.ofs_a, 1'b1);
						rx_latch_pkg::CMD_DEC_OFS_A: st_next.cur.ofs_a = step(st_reg.cur.ofs_a, 1'b0);
						rx_latch_pkg::CMD_INC_OFS_B: st_next.cur.ofs_b = step(st_reg.cur.ofs_b, 1'b1);
						rx_latch_pkg::CMD_DEC_OFS_B: st_next.cur.ofs_b = step(st_reg.cur.ofs_b, 1'b0);
						rx_latch_pkg::CMD_INIT: begin
							st_next.cur = st_reg.dflt;
							st_next.blank = 1'b0;
						end
						rx_latch_pkg::CMD_SAVE: st_next.dflt = st_reg.cur;
						rx_latch_pkg::CMD_QUAD_ENTER: st_next.blank = 1'b1;
						rx_latch_pkg::CMD_QUAD_LEAVE: st_next.blank = 1'b0;
						default: st_next.cur = st_reg.cur;
					endcase
				end
				default: st_next.cur = st_reg.cur;
			endcase
		end

		// a new error wins over a clear in the same cycle
		st_next.error = (st_reg.error && !(wr_go && idx == rx_latch_pkg::IDX_CMD
			&& cmd == rx_latch_pkg::CMD_CLR_ERR)) || error_event_i;

		if (st_reg.blank && st_reg.blink_cnt < 32'(BLINK_CYCLES - 1)) begin
			st_next.blink_cnt = st_reg.blink_cnt + 32'h0000_0001;
		end else begin
			st_next.blink_cnt = 32'h0000_0000;
			st_next.blink_ph = st_reg.blank && !st_reg.blink_ph;
		end

		// indicator priority: hold, error, blanked, flicker, idle
		if (pulse_hold) begin
			st_next.red = 1'b1;
			st_next.green = 1'b1;
		end else if (st_next.error) begin
			st_next.red = 1'b1;
			st_next.green = 1'b0;
		end else if (st_reg.blank) begin
			st_next.red = st_reg.blink_ph;
			st_next.green = 1'b1;
		end else begin
			st_next.red = 1'b0;
			st_next.green = !cmd_seen;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st_reg <= STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign readdata_o = st_reg.rdata;
	assign waitrequest_o = st_reg.wait_req;
	assign fine_attenuator_value_o = st_reg.cur.atten;
	assign quad_phase_trim_o = st_reg.cur.phase;
	assign quad_gain_trim_o = st_reg.cur.gtrim;
	assign switched_gain_stage_o = st_reg.cur.stage[rx_latch_pkg::SECOND_LSB-1:0];
	assign second_stage_gain_o = st_reg.cur.stage[rx_latch_pkg::SECOND_LSB +: rx_latch_pkg::SECOND_W];
	assign chan_a_offset_o = st_reg.cur.ofs_a;
	assign chan_b_offset_o = st_reg.cur.ofs_b;
	assign rx_gain_o = st_reg.cur.rx_gain;
	assign pulse_reset_inhibit_o = st_reg.blank;
	assign controller_hold_o = st_reg.hold;
	assign red_led_o = st_reg.red;
	assign green_led_o = st_reg.green;

endmodule

// ### verif/rx_latch_bank_chk.sv
// port assertions for the latch bank
`timescale 1ns/1ps
module rx_latch_bank_chk #(
	parameter int BLINK_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [17:0] address_i,
	input wire logic waitrequest_o,
	input wire logic acquisition_pulse_n_i,
	input wire logic error_event_i,
	input wire logic [7:0] fine_attenuator_value_o,
	input wire logic [7:0] quad_phase_trim_o,
	input wire logic [7:0] quad_gain_trim_o,
	input wire logic [15:0] rx_gain_o,
	input wire logic pulse_reset_inhibit_o,
	input wire logic controller_hold_o,
	input wire logic red_led_o,
	input wire logic green_led_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	// ----
	// handshake and latches
	// ----
	wait_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("request not answered");
	wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
		else $error("wait low too long");
	latch_hold_a: assert property (!(write_i && !waitrequest_o)
		|=> $stable({fine_attenuator_value_o, quad_phase_trim_o, quad_gain_trim_o, pulse_reset_inhibit_o}))
		else $error("latch moved without write");
	gain_range_a: assert property (rx_gain_o >= 16'h0001 && rx_gain_o <= 16'hb505)
		else $error("gain out of range");
	// ----
	// hold and indicators
	// ----
	hold_cause_a: assert property (!acquisition_pulse_n_i && !pulse_reset_inhibit_o
		|=> controller_hold_o) else $error("hold missing");
	hold_free_a: assert property (acquisition_pulse_n_i || pulse_reset_inhibit_o
		|=> !controller_hold_o) else $error("hold unexpected");
	hold_leds_a: assert property (controller_hold_o && $past(controller_hold_o)
		|-> red_led_o && green_led_o) else $error("hold leds wrong");
	error_leds_a: assert property (error_event_i && acquisition_pulse_n_i && !controller_hold_o
		|=> red_led_o && !green_led_o) else $error("error leds wrong");
	flicker_short_a: assert property (!green_led_o && !red_led_o && !error_event_i
		|=> green_led_o) else $error("flicker too long");
	cmd_flicker_a: assert property (write_i && waitrequest_o && address_i[17:2] == 16'h8013 && acquisition_pulse_n_i
		&& !pulse_reset_inhibit_o && !red_led_o && !error_event_i |=> !green_led_o) else $error("no command flicker");
	cover property (controller_hold_o);
	cover property (!green_led_o && !red_led_o);
	cover property (red_led_o && !green_led_o);
	cover property (pulse_reset_inhibit_o && !acquisition_pulse_n_i);
endmodule

// ### verif/uc_master.sv
// board microcontroller model: bus master for the latch bank
`timescale 1ns/1ps
module uc_master (
	input wire logic clk_i,
	input wire logic waitrequest_i,
	input wire logic [31:0] readdata_i,
	output logic [17:0] address_o,
	output logic read_o,
	output logic write_o,
	output logic [31:0] writedata_o,
	output logic [3:0] byteenable_o
);
	bit timed_out = 1'b0;
	initial begin
		address_o = 18'h0;
		read_o = 1'b0;
		write_o = 1'b0;
		writedata_o = 32'h0;
		byteenable_o = 4'h0;
	end
	// request held until waitrequest seen low; bounded wait
	task automatic xfer(input logic w, input logic [15:0] idx, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		address_o <= {idx, 2'b00};
		writedata_o <= d;
		byteenable_o <= be;
		read_o <= !w;
		write_o <= w;
		do begin
			@(posedge clk_i);
			n++;
		end while (waitrequest_i && n < 20);
		q = readdata_i;
		timed_out = waitrequest_i;
		read_o <= 1'b0;
		write_o <= 1'b0;
		// released lines show no stale value
		address_o <= ~address_o;
		writedata_o <= ~writedata_o;
	endtask
endmodule

// ### verif/receiver_gain_adjust_latches_bench.sv
// self-checking bench for the latch bank
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; $display("Error at %0t: got %h exp %h", $time, a, e); end end
module receiver_gain_adjust_latches_bench;
	logic clk_i, arst_n_i, read_i, write_i, waitrequest_o, acquisition_pulse_n_i, error_event_i;
	logic [17:0] address_i;
	logic [31:0] writedata_i, readdata_o, q;
	logic [3:0] byteenable_i;
	logic [7:0] atten, phase, gtrim, ofs_a, ofs_b;
	logic [7:0] stage_lo;
	logic [1:0] stage_hi;
	logic [15:0] rx_gain_o;
	logic inhibit, hold, red, green, prev;
	logic [15:0] idx_tab [4] = '{16'h8002, 16'h8001, 16'h8010, 16'h8011};
	int fails = 0;
	int cmp_count = 0;
	int n;
	int flicks = 0;
	rx_latch_bank #(.BLINK_CYCLES(4)) DUT (.clk_i, .arst_n_i, .address_i, .read_i, .write_i, .writedata_i,
		.byteenable_i, .acquisition_pulse_n_i, .error_event_i, .readdata_o, .waitrequest_o,
		.fine_attenuator_value_o(atten), .quad_phase_trim_o(phase), .quad_gain_trim_o(gtrim),
		.switched_gain_stage_o(stage_lo), .second_stage_gain_o(stage_hi), .chan_a_offset_o(ofs_a),
		.chan_b_offset_o(ofs_b), .rx_gain_o, .pulse_reset_inhibit_o(inhibit), .controller_hold_o(hold),
		.red_led_o(red), .green_led_o(green));
	uc_master u_mst (.clk_i, .waitrequest_i(waitrequest_o), .readdata_i(readdata_o), .address_o(address_i),
		.read_o(read_i), .write_o(write_i), .writedata_o(writedata_i), .byteenable_o(byteenable_i));
	// ----
	// tasks
	// ----
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic acc(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic [3:0] be);
		u_mst.xfer(w, idx, d, be, q);
		#1;
		if (u_mst.timed_out) begin
			fails++;
			$display("Error at %0t: no answer", $time);
			stop_test();
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		acc(1'b1, idx, d, 4'hf);
	endtask
	task automatic cmd(input logic [3:0] c);
		wr(16'h8013, {28'h0, c});
	endtask
	task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
		acc(1'b0, idx, 32'h0, 4'hf);
		`CHK(q, e)
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// counts cycles with both indicators dark, i.e. command flickers
	always @(posedge clk_i) begin
		if (green === 1'b0 && red === 1'b0) begin
			flicks++;
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		arst_n_i = 1'b0;
		error_event_i = 1'b0;
		acquisition_pulse_n_i = 1'b1;
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'b1;
		#1;
		`CHK({atten, ofs_a, red, green}, 18'h00201)
		wr(16'h8000, 32'h5a);
		wr(16'h8001, 32'h3c);
		wr(16'h8002, 32'hc3);
		`CHK({atten, phase, gtrim}, 24'h5a3cc3)
		wr(16'h8006, 32'h1);
		wr(16'h8007, 32'h24);
		`CHK({stage_hi, stage_lo}, 10'h241)
		acc(1'b1, 16'h8000, 32'h77, 4'he);
		`CHK(atten, 8'h5a)
		rd_chk(16'h0000, 32'h0);
		wr(16'h8012, 32'hffff);
		rd_chk(16'h8012, 32'hb505);
		`CHK(rx_gain_o, 16'hb505)
		wr(16'h8012, 32'h0);
		rd_chk(16'h8012, 32'h1);
		for (int i = 0; i < 4; i++) begin
			wr(idx_tab[i], 32'hfe);
			cmd(4'(2 * i + 1));
			rd_chk(idx_tab[i], 32'hff);
			cmd(4'(2 * i + 1));
			rd_chk(idx_tab[i], 32'hff);
			cmd(4'(2 * i + 2));
			rd_chk(idx_tab[i], 32'hfe);
		end
		`CHK({ofs_a, ofs_b}, 16'hfefe)
		wr(16'h8000, 32'h33);
		n = flicks;
		cmd(4'ha);
		`CHK(flicks - n, 1)
		wr(16'h8000, 32'h44);
		cmd(4'h9);
		`CHK({atten, gtrim}, 16'h33fe)
		@(posedge clk_i);
		error_event_i <= 1'b1;
		@(posedge clk_i);
		error_event_i <= 1'b0;
		#1;
		`CHK({red, green}, 2'b10)
		wr(16'h8000, 32'h55);
		`CHK(atten, 8'h33)
		rd_chk(16'h8014, 32'h09);
		cmd(4'hb);
		cyc(2);
		`CHK({red, green}, 2'b01)
		@(posedge clk_i);
		acquisition_pulse_n_i <= 1'b0;
		cyc(3);
		`CHK({hold, red, green}, 3'b111)
		wr(16'h8000, 32'h66);
		`CHK(atten, 8'h33)
		@(posedge clk_i);
		acquisition_pulse_n_i <= 1'b1;
		cyc(3);
		`CHK(hold, 1'b0)
		cmd(4'hc);
		`CHK(inhibit, 1'b1)
		@(posedge clk_i);
		acquisition_pulse_n_i <= 1'b0;
		wr(16'h8010, 32'h12);
		`CHK({hold, ofs_a}, 9'h012)
		// blink period is short here, so a dozen cycles show several toggles
		n = 0;
		prev = red;
		repeat (12) begin
			cyc(1);
			n += int'(red !== prev);
			prev = red;
			`CHK(green, 1'b1)
		end
		`CHK(n >= 2, 1'b1)
		@(posedge clk_i);
		acquisition_pulse_n_i <= 1'b1;
		cmd(4'hd);
		`CHK(inhibit, 1'b0)
		stop_test();
	end
endmodule
bind rx_latch_bank rx_latch_bank_chk #(.BLINK_CYCLES(BLINK_CYCLES)) u_chk (.clk_i, .arst_n_i, .read_i, .write_i, .address_i,
	.waitrequest_o, .acquisition_pulse_n_i, .error_event_i, .fine_attenuator_value_o, .quad_phase_trim_o,
	.quad_gain_trim_o, .rx_gain_o, .pulse_reset_inhibit_o, .controller_hold_o, .red_led_o, .green_led_o);
